// ---- mcp_pkg.sv ----
// Shared constants, types and helpers of the motor commutation PWM block
package mcp_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_PRESC = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_POL = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_TIM = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_ZPRV = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_ZREG = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_COMP = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_DEMAG = 6'h2C;

  // Field positions
  localparam int unsigned CA_OE = 0;
  localparam int unsigned CA_AUTO = 1;
  localparam int unsigned CA_VC = 2;
  localparam int unsigned CA_SENSOR = 3;
  localparam int unsigned CB_FILT = 0;
  localparam int unsigned CB_STEER = 1;
  localparam int unsigned PR_RATIO = 0;
  localparam int unsigned PR_WIN = 4;
  localparam int unsigned PH_ACTIVE = 8;
  localparam int unsigned ST_DEC = 0;
  localparam int unsigned ST_INC = 1;
  localparam int unsigned ST_EMERG = 2;
  localparam int unsigned ST_COMM = 3;

  // Reset values and limits
  localparam logic [7:0] TIM_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] RATIO_MAX = 4'hF;
  localparam logic [7:0] TIM_FULL = 8'hFF;

  // Timing figures in their own units
  localparam int unsigned STEP_TICK_NS = 500;
  localparam int unsigned FILT_NS = 2500;
  localparam int unsigned OFF_SENSOR_NS = 1250;
  localparam int unsigned OFF_NS [4] = '{5000, 10000, 15000, 30000};
  localparam int unsigned WIN_HZ [16] = '{25000, 20000, 18100, 15400, 12500, 10000, 6250,
    3130, 1560, 1250, 1140, 961, 781, 625, 390, 195};

  typedef enum logic [1:0] {
    MCP_CONFIG = 2'b00,
    MCP_SWITCHED = 2'b01,
    MCP_AUTO = 2'b11,
    MCP_ESTOP = 2'b10
  } mcp_mode_e;

  typedef struct packed {
    logic sensor;
    logic vc_sel;
    logic auto_sw;
    logic oe;
  } mcp_ctrl_s;

  // Nanoseconds to clock cycles, rounded up, at least one
  function automatic int unsigned mcp_ns_cyc(input int unsigned ns, input int unsigned clk_hz);
    longint unsigned c;
    c = (longint'(ns) * (clk_hz / 1000) + 999_999) / 1_000_000;
    return (c == 0) ? 1 : int'(c);
  endfunction : mcp_ns_cyc

  function automatic int unsigned mcp_win_cyc(input logic [3:0] sel, input int unsigned clk_hz);
    return clk_hz / WIN_HZ[sel];
  endfunction : mcp_win_cyc

  function automatic int unsigned mcp_off_cyc(input logic sensor, input logic [1:0] sel,
                                              input int unsigned clk_hz);
    if (sensor)
    begin
      return mcp_ns_cyc(OFF_SENSOR_NS, clk_hz);
    end
    return mcp_ns_cyc(OFF_NS[sel], clk_hz);
  endfunction : mcp_off_cyc

  function automatic mcp_mode_e mcp_mode(input mcp_ctrl_s c);
    return mcp_mode_e'({c.auto_sw, c.oe});
  endfunction : mcp_mode

endpackage : mcp_pkg

// ---- mcp_blank_filter.sv ----
// Comparator blanking filter that hides trips just after PWM switch-on
`timescale 1ns/100ps
module mcp_blank_filter
  import mcp_pkg::*;
#(
  parameter int unsigned BLANK_CYC = 500
)(
  input wire logic clk_in, // Core clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic enable_in, // Filter enabled
  input wire logic on_pulse_in, // PWM switches on next cycle
  input wire logic trip_raw_in, // Raw comparator output
  output logic trip_out // Filtered comparator output
);

  typedef struct packed {
    logic [31:0] cnt;
  } mcp_filt_s;

  mcp_filt_s s_r;
  mcp_filt_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (on_pulse_in)
    begin
      s_nxt.cnt = BLANK_CYC;
    end
    else if (s_r.cnt != 0)
    begin
      s_nxt.cnt = s_r.cnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign trip_out = trip_raw_in & ~(enable_in & (s_r.cnt != 0));

endmodule : mcp_blank_filter

// ---- mcp_top.sv ----
// Motor commutation PWM: step timer, PWM manager and channel manager front end
`timescale 1ns/100ps
// Behaviour
// - each ratio code step halves timer rate
// - config and estop modes: timer registers writable
// - autoswitched: only demag writable, flags hardware-set
// - voltage mode PWM comes from timer A
// - voltage mode comparator trip cuts PWM
// - sensorless voltage sampling only during PWM off
// - current mode on at window end, off early
// - filter hides trips 2.5 us after on
// - window frequency from sixteen-step table
// - window marks sampling instant in current or sensor mode
// - sensorless window width from off-time field
// - sensor mode fixes window at 1.25 us
// - preload copied to phase on commutation
// - PWM steered to odd, even or both
// - emergency input floats outputs asynchronously
// - six channels, voltage or current mode
// - emergency clears enable, sets its flag, raises interrupt if masked in
// - autoswitched: timer at FFh bumps ratio, halves registers
module mcp_top
  import mcp_pkg::*;
#(
  parameter int unsigned CLK_HZ = 200_000_000,
  parameter int unsigned N_CHAN = 6
)(
  input wire logic clk_in, // Core clock, 200 MHz
  input wire logic rst_n_in, // Async reset, active low
  input wire logic [ADDR_W-1:0] avs_address_in, // Avalon byte address
  input wire logic avs_read_in, // Avalon read
  input wire logic avs_write_in, // Avalon write
  input wire logic [DATA_W-1:0] avs_writedata_in, // Avalon write data
  output logic [DATA_W-1:0] avs_readdata_out, // Avalon read data
  output logic avs_waitrequest_out, // Avalon wait request
  input wire logic timer_a_pwm_in, // PWM from 16-bit timer A
  input wire logic current_limit_in, // Comparator: sense reached reference
  input wire logic commutation_evt_in, // Commutation (C) event pulse
  input wire logic emergency_stop_input_n_in, // Emergency stop, active low
  output logic [N_CHAN-1:0] chan_out, // Motor channel levels
  output logic [N_CHAN-1:0] chan_oe_out, // Channel driver enables
  output logic sample_out, // Sampling window for detectors
  output logic pwm_out, // Resulting motor PWM
  output logic irq_out // Interrupt, active high level
);

  localparam int unsigned STEP_CYC = mcp_ns_cyc(STEP_TICK_NS, CLK_HZ);
  localparam int unsigned FILT_CYC = mcp_ns_cyc(FILT_NS, CLK_HZ);

  typedef struct packed {
    mcp_ctrl_s ctrl;
    logic filt_en;
    logic [1:0] steer;
    logic [3:0] ratio;
    logic [3:0] win_sel;
    logic [1:0] off_sel;
    logic [N_CHAN-1:0] preload;
    logic [N_CHAN-1:0] phase;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [7:0] tim;
    logic [7:0] zprv;
    logic [7:0] zreg;
    logic [7:0] comp;
    logic [7:0] demag;
    logic [31:0] pre_cnt;
    logic [31:0] win_cnt;
    logic pwm;
    logic wait_q;
    logic [DATA_W-1:0] rdata;
    logic [N_CHAN-1:0] chan;
    logic sample;
    logic irq;
  } mcp_state_s;

  mcp_state_s s_r;
  mcp_state_s s_nxt;
  logic trip;
  logic pwm_rise;
  mcp_mode_e mode;

  mcp_blank_filter #(
    .BLANK_CYC(FILT_CYC)
  ) u_filt (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(s_r.filt_en),
    .on_pulse_in(pwm_rise),
    .trip_raw_in(current_limit_in),
    .trip_out(trip)
  );

  assign mode = mcp_mode(s_r.ctrl);
  assign pwm_rise = s_nxt.pwm & ~s_r.pwm;

  always_comb
  begin
    logic [31:0] win_per;
    logic [31:0] off_cyc;
    logic [31:0] step_per;
    logic tick;
    logic in_win;
    logic open_rw;
    logic [7:0] wd;
    win_per = 32'(mcp_win_cyc(s_r.win_sel, CLK_HZ));
    off_cyc = 32'(mcp_off_cyc(s_r.ctrl.sensor, s_r.off_sel, CLK_HZ));
    step_per = 32'(STEP_CYC) << s_r.ratio;
    tick = 1'b0;
    in_win = s_r.win_cnt < off_cyc;
    open_rw = (mode == MCP_CONFIG) || (mode == MCP_ESTOP);
    wd = avs_writedata_in[7:0];
    s_nxt = s_r;

    // Register bus: one wait cycle, then the access completes
    if ((avs_read_in || avs_write_in) && s_r.wait_q)
    begin
      s_nxt.wait_q = 1'b0;
      s_nxt.rdata = '0;
      unique case (avs_address_in)
        OFS_CTRL_A: s_nxt.rdata[3:0] = s_r.ctrl;
        OFS_CTRL_B: s_nxt.rdata[2:0] = {s_r.steer, s_r.filt_en};
        OFS_PRESC: s_nxt.rdata[7:0] = {s_r.win_sel, s_r.ratio};
        OFS_POL: s_nxt.rdata[1:0] = s_r.off_sel;
        OFS_PHASE: s_nxt.rdata[13:0] = {s_r.phase, 2'b00, s_r.preload};
        OFS_STAT: s_nxt.rdata[3:0] = s_r.stat;
        OFS_MASK: s_nxt.rdata[3:0] = s_r.mask;
        OFS_TIM: s_nxt.rdata[7:0] = s_r.tim;
        OFS_ZPRV: s_nxt.rdata[7:0] = s_r.zprv;
        OFS_ZREG: s_nxt.rdata[7:0] = s_r.zreg;
        OFS_COMP: s_nxt.rdata[7:0] = s_r.comp;
        OFS_DEMAG: s_nxt.rdata[7:0] = s_r.demag;
        default: s_nxt.rdata = '0;
      endcase
    end
    else if (!s_r.wait_q)
    begin
      s_nxt.wait_q = 1'b1;
      if (avs_read_in && avs_address_in == OFS_STAT)
      begin
        s_nxt.stat = s_r.stat & ~s_r.rdata[3:0];
      end
      if (avs_write_in)
      begin
        unique case (avs_address_in)
          OFS_CTRL_A: s_nxt.ctrl = mcp_ctrl_s'(wd[3:0]);
          OFS_CTRL_B: {s_nxt.steer, s_nxt.filt_en} = wd[2:0];
          OFS_PRESC:
          begin
            s_nxt.win_sel = wd[7:4];
            if (open_rw)
            begin
              s_nxt.ratio = wd[3:0];
            end
          end
          OFS_POL: s_nxt.off_sel = wd[1:0];
          OFS_PHASE: s_nxt.preload = wd[N_CHAN-1:0];
          OFS_MASK: s_nxt.mask = wd[3:0];
          OFS_STAT:
          begin
            if (mode == MCP_SWITCHED && wd[ST_DEC] && s_r.ratio != 4'h0)
            begin
              s_nxt.ratio = s_r.ratio - 4'h1;
            end
            else if (mode == MCP_SWITCHED && wd[ST_INC] && s_r.ratio != RATIO_MAX)
            begin
              s_nxt.ratio = s_r.ratio + 4'h1;
            end
          end
          OFS_TIM: s_nxt.tim = open_rw ? wd : s_r.tim;
          OFS_ZPRV: s_nxt.zprv = open_rw ? wd : s_r.zprv;
          OFS_ZREG: s_nxt.zreg = open_rw ? wd : s_r.zreg;
          OFS_COMP: s_nxt.comp = (mode != MCP_AUTO) ? wd : s_r.comp;
          OFS_DEMAG: s_nxt.demag = wd;
          default: s_nxt.wait_q = 1'b1;
        endcase
      end
    end

    if (mode == MCP_SWITCHED || mode == MCP_AUTO)
    begin
      if (s_r.pre_cnt >= step_per - 32'h0000_0001)
      begin
        s_nxt.pre_cnt = '0;
        tick = 1'b1;
      end
      else
      begin
        s_nxt.pre_cnt = s_r.pre_cnt + 32'h0000_0001;
      end
    end
    else
    begin
      s_nxt.pre_cnt = '0;
    end
    if (tick)
    begin
      if (s_r.tim != TIM_FULL)
      begin
        s_nxt.tim = s_r.tim + 8'h01;
      end
      else if (mode == MCP_AUTO && s_r.ratio != RATIO_MAX)
      begin
        s_nxt.ratio = s_r.ratio + 4'h1;
        s_nxt.tim = s_r.tim >> 1;
        s_nxt.zprv = s_r.zprv >> 1;
        s_nxt.zreg = s_r.zreg >> 1;
        s_nxt.comp = s_r.comp >> 1;
        s_nxt.demag = s_r.demag >> 1;
        s_nxt.stat[ST_INC] = 1'b1;
      end
    end

    if (s_r.win_cnt >= win_per - 32'h0000_0001)
    begin
      s_nxt.win_cnt = '0;
    end
    else
    begin
      s_nxt.win_cnt = s_r.win_cnt + 32'h0000_0001;
    end

    if (s_r.ctrl.vc_sel)
    begin
      if (s_r.win_cnt == off_cyc)
      begin
        s_nxt.pwm = 1'b1;
      end
      else if (s_r.win_cnt == 32'h0000_0000 || trip)
      begin
        s_nxt.pwm = 1'b0;
      end
    end
    else
    begin
      s_nxt.pwm = timer_a_pwm_in & ~trip;
    end

    if (!s_r.ctrl.vc_sel && !s_r.ctrl.sensor)
    begin
      s_nxt.sample = ~s_nxt.pwm;
    end
    else
    begin
      s_nxt.sample = in_win;
    end

    if (commutation_evt_in)
    begin
      s_nxt.phase = s_r.preload;
      s_nxt.stat[ST_COMM] = 1'b1;
    end

    for (int i = 0; i < N_CHAN; i++)
    begin
      if (s_r.steer[i % 2 == 1 ? 0 : 1])
      begin
        s_nxt.chan[i] = s_r.phase[i] & s_nxt.pwm;
      end
      else
      begin
        s_nxt.chan[i] = s_r.phase[i];
      end
    end

    if (!emergency_stop_input_n_in)
    begin
      s_nxt.ctrl.oe = 1'b0;
      s_nxt.stat[ST_EMERG] = 1'b1;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_r <= '{wait_q: 1'b1, mask: MASK_RST, tim: TIM_RST, default: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_out = s_r.rdata;
  assign avs_waitrequest_out = s_r.wait_q;
  assign chan_out = s_r.chan;
  assign sample_out = s_r.sample;
  assign pwm_out = s_r.pwm;
  assign irq_out = s_r.irq;
  assign chan_oe_out = {N_CHAN{s_r.ctrl.oe & emergency_stop_input_n_in}};

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_phase_load: assert property (commutation_evt_in |=> s_r.phase == $past(s_r.preload))
    else $error("phase not loaded on commutation");
  a_phase_hold: assert property (!commutation_evt_in |=> $stable(s_r.phase))
    else $error("phase changed without commutation");
  a_emerg_oe: assert property (!emergency_stop_input_n_in |=> !s_r.ctrl.oe && s_r.stat[ST_EMERG])
    else $error("emergency did not clear enable");
  a_emerg_irq: assert property (!emergency_stop_input_n_in && s_r.mask[ST_EMERG] |=> irq_out)
    else $error("emergency interrupt missing");
  a_tristate_now: assert property (!emergency_stop_input_n_in |-> chan_oe_out == '0)
    else $error("outputs not floated");
  a_volt_pwm: assert property (!s_r.ctrl.vc_sel && timer_a_pwm_in && !trip |=> s_r.pwm)
    else $error("voltage pwm not following timer");
  a_volt_limit: assert property (!s_r.ctrl.vc_sel && trip |=> !s_r.pwm)
    else $error("current limit ignored");
  a_curr_trip: assert property (s_r.ctrl.vc_sel && $changed(s_r.ctrl) == 0 && trip
    && s_r.win_cnt != 32'(mcp_off_cyc(s_r.ctrl.sensor, s_r.off_sel, CLK_HZ)) |=> !s_r.pwm)
    else $error("current pwm not ended by trip");
  a_sample_off: assert property (!s_r.ctrl.vc_sel && !s_r.ctrl.sensor && s_r.sample
    |-> !s_r.pwm)
    else $error("sampling during pwm on");
  a_auto_locked: assert property (mode == MCP_AUTO && avs_write_in
    && !avs_waitrequest_out && avs_address_in == OFS_COMP
    |=> s_r.comp == $past(s_r.comp) || s_r.comp == $past(s_r.comp) >> 1)
    else $error("compare written in autoswitched mode");
  a_ratio_sat: assert property (mode == MCP_SWITCHED && s_r.ratio == RATIO_MAX
    && avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_STAT
    && avs_writedata_in[ST_INC] && !avs_writedata_in[ST_DEC] |=> s_r.ratio == RATIO_MAX)
    else $error("ratio wrapped");
  a_filt_blank: assert property (s_r.filt_en && pwm_rise |=> !trip [*3])
    else $error("trip not blanked after switch-on");

  c_commutation: cover property (commutation_evt_in ##1 s_r.phase != 6'h00);
  c_auto_bump: cover property (mode == MCP_AUTO && s_nxt.stat[ST_INC] && !s_r.stat[ST_INC]);
  c_curr_cycle: cover property (s_r.ctrl.vc_sel && pwm_rise ##[1:1000] !s_r.pwm);
  c_emergency: cover property (s_r.ctrl.oe ##1 !s_r.ctrl.oe && irq_out);

endmodule : mcp_top

// ---- mcp_bridge_model.sv ----
// Behavioural power bridge and winding whose current builds while a switch conducts
`timescale 1ns/100ps
module mcp_bridge_model (
  input wire logic clk_in, // Core clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic [5:0] drive_in, // Channel levels from the block
  input wire logic [5:0] drive_oe_in, // Channel driver enables
  input wire logic [7:0] limit_in, // Trip level in cycles, zero never trips
  output logic trip_out // Sensed current at or above reference
);
  logic [7:0] amps_r;
  logic on;
  assign on = |(drive_in & drive_oe_in);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      amps_r <= 8'h00;
    end
    else
    begin
      amps_r <= !on ? 8'h00 : (amps_r == 8'hFF ? amps_r : amps_r + 8'h01);
    end
  end
  // Current clears on the clock after all switches open, so a trip outlasts switch-off by one cycle
  assign trip_out = (limit_in != 8'h00) && (amps_r >= limit_in);
endmodule : mcp_bridge_model

// ---- tb_top.sv ----
// Self-checking testbench of the motor commutation PWM block
`timescale 1ns/100ps
module tb_top;
  import mcp_pkg::*;
  localparam int unsigned CLK = 2_000_000;
  logic clk_in, rst_n_in, avs_read_in, avs_write_in, timer_a_pwm_in, current_limit_in;
  logic commutation_evt_in, emergency_stop_input_n_in, avs_waitrequest_out;
  logic sample_out, pwm_out, irq_out;
  logic [ADDR_W-1:0] avs_address_in;
  logic [DATA_W-1:0] avs_writedata_in, avs_readdata_out, rdata;
  logic [5:0] chan_out, chan_oe_out;
  logic [7:0] limit;
  int err_total, check_count, hi, per, pw;
  int cyc = 0;

  mcp_top #(.CLK_HZ(CLK), .N_CHAN(6)) uut (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .timer_a_pwm_in,
    .current_limit_in, .commutation_evt_in, .emergency_stop_input_n_in, .chan_out, .chan_oe_out,
    .sample_out, .pwm_out, .irq_out);
  mcp_bridge_model bridge (.clk_in, .rst_n_in, .drive_in(chan_out), .drive_oe_in(chan_oe_out),
    .limit_in(limit), .trip_out(current_limit_in));

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task conclude();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // Cuts a hang short
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      err_total++;
      conclude();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task near(input int got, input int exp, input int tol);
    check_count++;
    if (got > exp + tol || got < exp - tol)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near

  // One Avalon access, held until waitrequest is sampled low
  task acc(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= DATA_W'(d);
    avs_write_in <= w;
    avs_read_in <= !w;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
    rdata = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : acc

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_cyc

  task pulse_c();
    @(posedge clk_in);
    commutation_evt_in <= 1'b1;
    @(posedge clk_in);
    commutation_evt_in <= 1'b0;
    wait_cyc(2);
  endtask : pulse_c

  // One full window period: high time, period and PWM on time
  task meas();
    logic last;
    while (sample_out !== 1'b0) @(posedge clk_in);
    while (sample_out !== 1'b1) @(posedge clk_in);
    hi = 0;
    per = 0;
    pw = 0;
    do
    begin
      last = sample_out;
      @(posedge clk_in);
      per++;
      hi += int'(sample_out === 1'b1);
      pw += int'(pwm_out === 1'b1);
    end while (!(last === 1'b0 && sample_out === 1'b1));
  endtask : meas

  task run(input logic [7:0] pol, input logic [7:0] presc, input logic [7:0] mode);
    acc(1'b1, OFS_CTRL_A, mode & 8'hFE);
    acc(1'b1, OFS_POL, pol);
    acc(1'b1, OFS_PRESC, presc);
    acc(1'b1, OFS_CTRL_A, mode);
    meas();
  endtask : run

  task t_cfg();
    acc(1'b0, OFS_TIM, 8'h00);
    chk(rdata[7:0], TIM_RST);
    acc(1'b1, OFS_TIM, 8'h5A);
    acc(1'b1, OFS_ZPRV, 8'hA5);
    acc(1'b0, OFS_TIM, 8'h00);
    chk(rdata[7:0], 8'h5A);
    acc(1'b0, OFS_ZPRV, 8'h00);
    chk(rdata[7:0], 8'hA5);
    acc(1'b1, 6'h30, 8'hFF);
    acc(1'b0, 6'h30, 8'h00);
    chk(rdata[7:0] | rdata[31:24], 8'h00);
  endtask : t_cfg

  task t_commut();
    acc(1'b0, OFS_STAT, 8'h00);
    acc(1'b1, OFS_MASK, 8'h08);
    acc(1'b1, OFS_PHASE, 8'h2A);
    acc(1'b0, OFS_PHASE, 8'h00);
    chk({2'b00, rdata[13:8]}, 8'h00);
    pulse_c();
    acc(1'b0, OFS_PHASE, 8'h00);
    chk({2'b00, rdata[13:8]}, 8'h2A);
    chk({7'h00, irq_out}, 8'h01);
    acc(1'b0, OFS_STAT, 8'h00);
    chk(rdata[7:0] & 8'h08, 8'h08);
    wait_cyc(2);
    chk({7'h00, irq_out}, 8'h00);
    acc(1'b1, OFS_MASK, 8'h00);
  endtask : t_commut

  task t_switched();
    acc(1'b1, OFS_PRESC, 8'h03);
    acc(1'b1, OFS_TIM, 8'h00);
    acc(1'b1, OFS_CTRL_A, 8'h01);
    wait_cyc(160);
    acc(1'b0, OFS_TIM, 8'h00);
    near(int'(rdata[7:0]), 20, 1);
    acc(1'b1, OFS_ZREG, 8'h33);
    acc(1'b1, OFS_COMP, 8'h44);
    acc(1'b1, OFS_PRESC, 8'h09);
    acc(1'b0, OFS_ZREG, 8'h00);
    chk(rdata[7:0], 8'h00);
    acc(1'b0, OFS_COMP, 8'h00);
    chk(rdata[7:0], 8'h44);
    acc(1'b0, OFS_PRESC, 8'h00);
    chk({4'h0, rdata[3:0]}, 8'h03);
    repeat (4) acc(1'b1, OFS_STAT, 8'h01);
    acc(1'b0, OFS_PRESC, 8'h00);
    chk({4'h0, rdata[3:0]}, 8'h00);
    repeat (16) acc(1'b1, OFS_STAT, 8'h02);
    acc(1'b0, OFS_PRESC, 8'h00);
    chk({4'h0, rdata[3:0]}, 8'h0F);
  endtask : t_switched

  task t_voltage();
    acc(1'b1, OFS_CTRL_B, 8'h02);
    acc(1'b1, OFS_PHASE, 8'h3F);
    pulse_c();
    timer_a_pwm_in <= 1'b1;
    wait_cyc(4);
    chk({7'h00, pwm_out}, 8'h01);
    chk({2'b00, chan_out}, 8'h3F);
    chk({7'h00, sample_out}, 8'h00);
    timer_a_pwm_in <= 1'b0;
    wait_cyc(4);
    chk({7'h00, pwm_out}, 8'h00);
    chk({2'b00, chan_out}, 8'h15);
    chk({7'h00, sample_out}, 8'h01);
    limit <= 8'h08;
    timer_a_pwm_in <= 1'b1;
    wait_cyc(20);
    chk({7'h00, pwm_out}, 8'h00);
    timer_a_pwm_in <= 1'b0;
    limit <= 8'h00;
  endtask : t_voltage

  task t_current();
    acc(1'b1, OFS_CTRL_B, 8'h06);
    for (int k = 0; k < 4; k++)
    begin
      run(8'(k), 8'h00, 8'h05);
      near(hi, OFF_NS[k] * (CLK / 1_000_000) / 1000, 1);
      near(pw, per - hi, 1);
    end
    run(8'h00, 8'h00, 8'h0D);
    near(hi, (1250 * (CLK / 1_000_000) + 999) / 1000, 1);
    for (int s = 0; s < 16; s++)
    begin
      run(8'h00, {4'(s), 4'h0}, 8'h05);
      near(per, CLK / WIN_HZ[s], 1);
    end
    limit <= 8'h02;
    run(8'h00, 8'h00, 8'h05);
    near(pw, 4, 3);
    acc(1'b1, OFS_CTRL_B, 8'h07);
    meas();
    near(pw, 8, 3);
    limit <= 8'h00;
  endtask : t_current

  task t_auto();
    acc(1'b1, OFS_CTRL_A, 8'h00);
    acc(1'b1, OFS_PRESC, 8'h00);
    acc(1'b1, OFS_TIM, 8'h00);
    acc(1'b0, OFS_STAT, 8'h00);
    acc(1'b1, OFS_COMP, 8'h20);
    acc(1'b1, OFS_CTRL_A, 8'h03);
    acc(1'b1, OFS_DEMAG, 8'h12);
    acc(1'b1, OFS_COMP, 8'h55);
    acc(1'b0, OFS_COMP, 8'h00);
    chk(rdata[7:0], 8'h20);
    wait_cyc(280);
    acc(1'b0, OFS_PRESC, 8'h00);
    chk({4'h0, rdata[3:0]}, 8'h01);
    acc(1'b0, OFS_DEMAG, 8'h00);
    chk(rdata[7:0], 8'h09);
    acc(1'b0, OFS_COMP, 8'h00);
    chk(rdata[7:0], 8'h10);
    acc(1'b0, OFS_STAT, 8'h00);
    chk(rdata[7:0] & 8'h02, 8'h02);
    acc(1'b0, OFS_STAT, 8'h00);
    chk(rdata[7:0] & 8'h02, 8'h00);
  endtask : t_auto

  task t_estop();
    acc(1'b1, OFS_CTRL_A, 8'h00);
    acc(1'b0, OFS_STAT, 8'h00);
    acc(1'b1, OFS_MASK, 8'h04);
    acc(1'b1, OFS_CTRL_A, 8'h01);
    wait_cyc(2);
    chk({2'b00, chan_oe_out}, 8'h3F);
    emergency_stop_input_n_in <= 1'b0;
    #1;
    chk({2'b00, chan_oe_out}, 8'h00);
    wait_cyc(3);
    chk({7'h00, irq_out}, 8'h01);
    acc(1'b0, OFS_CTRL_A, 8'h00);
    chk({7'h00, rdata[0]}, 8'h00);
    acc(1'b0, OFS_STAT, 8'h00);
    chk(rdata[7:0] & 8'h04, 8'h04);
    emergency_stop_input_n_in <= 1'b1;
    acc(1'b1, OFS_CTRL_A, 8'h02);
    acc(1'b1, OFS_TIM, 8'h21);
    acc(1'b0, OFS_TIM, 8'h00);
    chk(rdata[7:0], 8'h21);
  endtask : t_estop

  initial
  begin
    rst_n_in = 1'b0;
    avs_address_in = '0;
    avs_writedata_in = '0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    timer_a_pwm_in = 1'b0;
    commutation_evt_in = 1'b0;
    emergency_stop_input_n_in = 1'b1;
    limit = 8'h00;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_cfg();
    t_commut();
    t_switched();
    t_voltage();
    t_current();
    t_auto();
    t_estop();
    conclude();
  end
endmodule : tb_top
